// >>> common/irc_pkg.sv
// constants and types for the interrupt, reset and mode control
package irc_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLOCK_PERIOD_NS = 100; // 10 mhz logic clock
   localparam int MCYC_DIV = 48; // clocks per machine cycle
   localparam int POWERUP_MCYC = 1024; // oscillator settle, machine cycles
   // ****************************************
   // register indices (byte address is index times four)
   // ****************************************
   localparam logic [7:0] IDX_TIMER_STATUS = 8'h09;
   localparam logic [7:0] IDX_CRC_FIRST = 8'h0a;
   localparam logic [7:0] IDX_CRC_SECOND = 8'h0b;
   localparam logic [7:0] IDX_STATUS = 8'h0c;
   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int TSC_ZERO_BIT = 7;
   localparam int TSC_TIE_BIT = 6;
   localparam int ST_MASK_BIT = 0;
   localparam int ST_INTSEL_BIT = 1;
   localparam int ST_PEND_BIT = 2;
   localparam int ST_MODE_LSB = 4;
   localparam int ST_LOCK_BIT = 6;
   localparam logic [15:0] CRC_RESET = 16'h0000;
   localparam logic [15:0] CRC_POLY = 16'h1021; // x^16 + x^12 + x^5 + 1
   // ****************************************
   // vectors
   // ****************************************
   localparam logic [11:0] VEC_INT_NORMAL = 12'hffc;
   localparam logic [11:0] VEC_INT_SELF = 12'hff8;
   localparam logic [11:0] VEC_RST_NORMAL = 12'hffe;
   localparam logic [11:0] VEC_RST_SELF = 12'hffa;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      IRC_SINGLE, IRC_SELF_CHECK, IRC_NON_USER, IRC_ROM_VERIFY
   } irc_mode_type;
   typedef enum logic [1:0] {
      IRC_POWERUP, IRC_RESET_CYCLE, IRC_RUN, IRC_ENTRY
   } irc_state_type;
endpackage

// >>> common/irc_crc_if.sv
// link between the control block and the signature registers
`timescale 1ns/1ps
`default_nettype none
interface irc_crc_if;
   logic wr_first;
   logic wr_second;
   logic [7:0] wdata;
   logic bit_valid;
   logic bit_in;
   logic lock_en;
   logic [7:0] first_q;
   logic [7:0] second_q;
   logic locked;
   modport ctl (output wr_first, wr_second, wdata, bit_valid, bit_in, lock_en,
                input first_q, second_q, locked);
   modport crc (input wr_first, wr_second, wdata, bit_valid, bit_in, lock_en,
                output first_q, second_q, locked);
endinterface
`default_nettype wire

// >>> verilog/irc_crc.sv
// two byte signature shift register pair
`timescale 1ns/1ps
`default_nettype none
module irc_crc (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // control side
   irc_crc_if.crc bus
);
   typedef struct packed {
      logic [15:0] crc;
      logic locked;
   } irc_crc_state_type;

   irc_crc_state_type s_r;
   irc_crc_state_type s_nxt;
   logic fb;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      fb = s_r.crc[15] ^ bus.bit_in;
      if (bus.wr_first || bus.wr_second) begin
         if (bus.wr_first) begin
            s_nxt.crc[15:8] = bus.wdata;
         end
         if (bus.wr_second) begin
            s_nxt.crc[7:0] = bus.wdata;
         end
         if (bus.lock_en) begin
            s_nxt.locked = 1'b1;
         end
      end else if (bus.bit_valid && !s_r.locked) begin
         // one data bit per update
         s_nxt.crc = {s_r.crc[14:0], 1'b0} ^ (fb ? irc_pkg::CRC_POLY : 16'h0000);
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{crc: irc_pkg::CRC_RESET, locked: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.first_q = s_r.crc[15:8];
   assign bus.second_q = s_r.crc[7:0];
   assign bus.locked = s_r.locked;

   // ****************************************
   // checks
   // ****************************************
   crc_lock_a: assert property (@(posedge clock) disable iff (!rst_n)
      (bus.wr_first || bus.wr_second) && bus.lock_en |=> s_r.locked [*2])
      else $error("write did not freeze signature");
   crc_step_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.bit_valid && !s_r.locked && !bus.wr_first && !bus.wr_second |=>
      s_r.crc == (({$past(s_r.crc[14:0]), 1'b0}) ^
      (($past(s_r.crc[15]) ^ $past(bus.bit_in)) ? irc_pkg::CRC_POLY : 16'h0000)))
      else $error("signature step wrong");
endmodule
`default_nettype wire

// >>> verilog/irc_top.sv
// interrupt, reset and operating mode control with signature registers
// Notes on behaviour
// - low irq input requests, edge or level
// - low power: timer underflow interrupts when enabled
// - edge option: falling input sets request latch
// - test request at instruction end, mask clear
// - one cycle entry: flags, push, mask, vector
// - vector word runs as instruction, needs jump
// - entry saves only the program counter
// - return clears mask, reselects program flags
// - new edge latched in service, served after
// - original runs two instructions; low power not
// - latency one to six machine cycles
// - level option: no latch, no clear
// - reset from power up or external pin
// - low power: timer delays until oscillator settles
// - reset cycle sets mask, loads restart vector
// - select high: latch and decode strap pins
// - select grounded: single chip mode
// - non user mode: ports fetch external code
// - two 8-bit signature registers in data space
// - low power, single chip or non user mode: write makes them plain storage
// - timer zero flag cleared by status read
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module irc_top #(
   parameter int MCYC_DIV_P = irc_pkg::MCYC_DIV,
   parameter int POWERUP_MCYC_P = irc_pkg::POWERUP_MCYC,
   parameter bit EDGE_SENSE = 1'b1,
   parameter bit LOW_POWER = 1'b1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register bus
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // pins
   input wire logic irq_n,
   input wire logic mode_select_pin,
   input wire logic mode_strap_hi,
   input wire logic mode_strap_lo,
   // core sequencer
   input wire logic instr_end,
   input wire logic rti_final,
   input wire logic timer_underflow,
   input wire logic crc_bit_valid,
   input wire logic crc_bit,
   // control outputs
   output logic mcyc_en,
   output logic core_run,
   output logic int_entry,
   output logic push_pc,
   output logic reset_cycle,
   output logic [11:0] vector,
   output logic int_flags_sel,
   output logic int_mask,
   output logic [1:0] op_mode,
   output logic ext_fetch
);
   localparam int DIV_W = $clog2(MCYC_DIV_P);
   localparam int PU_W = $clog2(POWERUP_MCYC_P + 1);

   typedef struct packed {
      irc_pkg::irc_state_type st;
      logic [DIV_W-1:0] div;
      logic [PU_W-1:0] pu_cnt;
      logic irq_prev;
      logic latch;
      logic mask;
      logic int_sel;
      logic hold;
      irc_pkg::irc_mode_type mode;
      logic tie;
      logic zero;
      logic ack;
      logic [7:0] rdata;
      logic [11:0] vector;
   } irc_state_type2_type;

   irc_state_type2_type s_r;
   irc_state_type2_type s_nxt;
   irc_crc_if crc_if ();

   logic mcyc;
   logic fall;
   logic ext_req;
   logic tmr_req;
   logic req;
   logic acc;
   logic done;
   logic [7:0] idx;
   logic mask_eff;
   logic hold_eff;
   logic [7:0] rd_val;
   irc_pkg::irc_mode_type new_mode;

   // ****************************************
   // helpers
   // ****************************************
   // register index from a byte address
   function automatic logic [7:0] reg_idx(input logic [9:0] a);
      return a[9:2];
   endfunction

   // vector for entry or restart in a mode
   function automatic logic [11:0] pick_vec(input irc_pkg::irc_mode_type m,
                                            input logic rst);
      logic self;
      self = (m == irc_pkg::IRC_SELF_CHECK);
      if (rst) begin
         return self ? irc_pkg::VEC_RST_SELF : irc_pkg::VEC_RST_NORMAL;
      end
      return self ? irc_pkg::VEC_INT_SELF : irc_pkg::VEC_INT_NORMAL;
   endfunction

   // ****************************************
   // request sources and bus decode
   // ****************************************
   assign mcyc = (s_r.div == DIV_W'(MCYC_DIV_P - 1));
   assign fall = s_r.irq_prev & ~irq_n;
   assign ext_req = EDGE_SENSE ? s_r.latch : ~irq_n;
   assign tmr_req = LOW_POWER & s_r.tie & s_r.zero;
   assign req = ext_req | tmr_req;
   assign acc = avs_read | avs_write;
   assign done = acc & s_r.ack;
   assign idx = reg_idx(avs_address);
   assign new_mode = mode_select_pin ?
      irc_pkg::irc_mode_type'({mode_strap_hi, mode_strap_lo}) : irc_pkg::IRC_SINGLE;

   // read value of the addressed register
   always_comb begin
      rd_val = 8'h00;
      if (avs_address[1:0] == 2'b00) begin
         case (idx)
            irc_pkg::IDX_TIMER_STATUS: begin
               rd_val[irc_pkg::TSC_ZERO_BIT] = s_r.zero;
               rd_val[irc_pkg::TSC_TIE_BIT] = s_r.tie;
            end
            irc_pkg::IDX_CRC_FIRST: rd_val = crc_if.first_q;
            irc_pkg::IDX_CRC_SECOND: rd_val = crc_if.second_q;
            irc_pkg::IDX_STATUS: begin
               rd_val[irc_pkg::ST_MASK_BIT] = s_r.mask;
               rd_val[irc_pkg::ST_INTSEL_BIT] = s_r.int_sel;
               rd_val[irc_pkg::ST_PEND_BIT] = req;
               rd_val[irc_pkg::ST_MODE_LSB +: 2] = s_r.mode;
               rd_val[irc_pkg::ST_LOCK_BIT] = crc_if.locked;
            end
            default: rd_val = 8'h00;
         endcase
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      mask_eff = s_r.mask;
      hold_eff = s_r.hold;
      s_nxt.div = mcyc ? '0 : DIV_W'(s_r.div + 1'b1);
      s_nxt.irq_prev = irq_n;
      // bus slave: one wait state, then the access completes
      s_nxt.ack = acc & ~s_r.ack;
      if (acc && !s_r.ack) begin
         s_nxt.rdata = rd_val;
      end
      // timer zero flag: status read clears, underflow wins
      if (avs_read && done && idx == irc_pkg::IDX_TIMER_STATUS) begin
         s_nxt.zero = 1'b0;
      end
      if (avs_write && done && avs_byteenable[0] && avs_address[1:0] == 2'b00
          && idx == irc_pkg::IDX_TIMER_STATUS) begin
         s_nxt.tie = avs_writedata[irc_pkg::TSC_TIE_BIT];
         if (avs_writedata[irc_pkg::TSC_ZERO_BIT]) begin
            s_nxt.zero = 1'b1;
         end
      end
      if (timer_underflow) begin
         s_nxt.zero = 1'b1;
      end
      // sequencer
      case (s_r.st)
         irc_pkg::IRC_POWERUP: begin
            s_nxt.mask = 1'b1;
            if (mcyc) begin
               if (!LOW_POWER || s_r.pu_cnt == '0) begin
                  s_nxt.st = irc_pkg::IRC_RESET_CYCLE;
                  s_nxt.mode = new_mode;
                  s_nxt.vector = pick_vec(new_mode, 1'b1);
               end else begin
                  s_nxt.pu_cnt = PU_W'(s_r.pu_cnt - 1'b1);
               end
            end
         end
         irc_pkg::IRC_RESET_CYCLE: begin
            s_nxt.mask = 1'b1;
            s_nxt.int_sel = 1'b0;
            if (mcyc) begin
               s_nxt.st = irc_pkg::IRC_RUN;
            end
         end
         irc_pkg::IRC_RUN: begin
            if (mcyc && rti_final) begin
               // return: unmask, program flags back
               s_nxt.mask = 1'b0;
               s_nxt.int_sel = 1'b0;
               mask_eff = 1'b0;
               s_nxt.hold = !LOW_POWER;
               hold_eff = !LOW_POWER;
            end else if (mcyc && instr_end) begin
               s_nxt.hold = 1'b0;
            end
            // decide at the instruction boundary
            if (mcyc && instr_end && req && !mask_eff && !hold_eff) begin
               s_nxt.st = irc_pkg::IRC_ENTRY;
               s_nxt.mask = 1'b1;
               s_nxt.int_sel = 1'b1;
               s_nxt.vector = pick_vec(s_r.mode, 1'b0);
            end
         end
         irc_pkg::IRC_ENTRY: begin
            if (mcyc) begin
               s_nxt.st = irc_pkg::IRC_RUN;
               s_nxt.latch = 1'b0;
            end
         end
         default: s_nxt.st = irc_pkg::IRC_POWERUP;
      endcase
      // with the edge option a new falling edge always lands in the latch
      if (EDGE_SENSE && fall) begin
         s_nxt.latch = 1'b1;
      end
      if (!EDGE_SENSE) begin
         s_nxt.latch = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{st: irc_pkg::IRC_POWERUP, div: '0,
                  pu_cnt: PU_W'(POWERUP_MCYC_P), irq_prev: 1'b1, latch: 1'b0,
                  mask: 1'b1, int_sel: 1'b0, hold: 1'b0,
                  mode: irc_pkg::IRC_SINGLE, tie: 1'b0, zero: 1'b0,
                  ack: 1'b0, rdata: 8'h00, vector: irc_pkg::VEC_RST_NORMAL};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // signature registers
   // ****************************************
   assign crc_if.wr_first = avs_write & done & avs_byteenable[0]
      & (avs_address[1:0] == 2'b00) & (idx == irc_pkg::IDX_CRC_FIRST);
   assign crc_if.wr_second = avs_write & done & avs_byteenable[0]
      & (avs_address[1:0] == 2'b00) & (idx == irc_pkg::IDX_CRC_SECOND);
   assign crc_if.wdata = avs_writedata[7:0];
   assign crc_if.bit_valid = crc_bit_valid;
   assign crc_if.bit_in = crc_bit;
   assign crc_if.lock_en = LOW_POWER & ((s_r.mode == irc_pkg::IRC_SINGLE)
      | (s_r.mode == irc_pkg::IRC_NON_USER));

   irc_crc u_crc (
      .clock(clock),
      .rst_n(rst_n),
      .bus(crc_if.crc)
   );

   // ****************************************
   // outputs
   // ****************************************
   assign avs_waitrequest = acc & ~s_r.ack;
   assign avs_readdata = {24'h000000, s_r.rdata};
   assign mcyc_en = mcyc;
   assign core_run = (s_r.st == irc_pkg::IRC_RUN);
   assign int_entry = (s_r.st == irc_pkg::IRC_ENTRY);
   assign push_pc = int_entry & mcyc; // only the counter is pushed
   assign reset_cycle = (s_r.st == irc_pkg::IRC_RESET_CYCLE);
   assign vector = s_r.vector;
   assign int_flags_sel = s_r.int_sel;
   assign int_mask = s_r.mask;
   assign op_mode = s_r.mode;
   assign ext_fetch = (s_r.mode == irc_pkg::IRC_NON_USER);

   // ****************************************
   // checks
   // ****************************************
   entry_masked_a: assert property (@(posedge clock) disable iff (!rst_n)
      int_entry |-> s_r.mask && s_r.int_sel)
      else $error("entry without mask or flags");
   entry_length_a: assert property (@(posedge clock) disable iff (!rst_n)
      int_entry && mcyc |=> core_run && !(EDGE_SENSE && !$past(fall) && s_r.latch))
      else $error("entry not one machine cycle");
   take_request_a: assert property (@(posedge clock) disable iff (!rst_n)
      core_run && mcyc && instr_end && !rti_final && req && !s_r.mask && !s_r.hold
      |=> int_entry && vector == pick_vec(s_r.mode, 1'b0))
      else $error("request not taken");
   rti_unmask_a: assert property (@(posedge clock) disable iff (!rst_n)
      core_run && mcyc && rti_final |=> (s_r.int_sel == int_entry) && (s_r.mask == int_entry))
      else $error("return did not unmask");
   edge_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
      EDGE_SENSE && fall |=> s_r.latch)
      else $error("edge not latched");
   level_nolatch_a: assert property (@(posedge clock) disable iff (!rst_n)
      !EDGE_SENSE |-> !s_r.latch)
      else $error("latch used in level option");
   masked_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      s_r.latch && s_r.mask && !int_entry |=> s_r.latch)
      else $error("masked request lost");
   restart_vec_a: assert property (@(posedge clock) disable iff (!rst_n)
      reset_cycle |-> s_r.mask && vector == pick_vec(s_r.mode, 1'b1))
      else $error("restart vector wrong");
   mode_ground_a: assert property (@(posedge clock) disable iff (!rst_n)
      s_r.st == irc_pkg::IRC_POWERUP && mcyc && !mode_select_pin && reset_cycle == 1'b0
      ##1 reset_cycle |-> op_mode == 2'b00)
      else $error("grounded select not single chip");
   zero_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      avs_read && done && idx == irc_pkg::IDX_TIMER_STATUS && !timer_underflow
      |=> !s_r.zero)
      else $error("status read did not clear zero flag");
endmodule
`default_nettype wire

// >>> dv/irc_partner.sv
// interrupt source, reset circuit and strap pins facing the control block
`timescale 1ns/1ps
`default_nettype none
module irc_partner #(
   parameter int MCYC_P = 4
) (
   // clock
   input wire logic clock,
   // pins toward the block
   output logic rst_n,
   output logic irq_n,
   output logic mode_select_pin,
   output logic mode_strap_hi,
   output logic mode_strap_lo
);
   // request line rests at its pull-up level
   initial begin
      irq_n = 1'b1;
   end

   // assert reset and present the straps for the coming exit
   task automatic reset_on(input logic sel, input logic [1:0] st);
      rst_n <= 1'b0;
      mode_select_pin <= sel;
      mode_strap_hi <= st[1];
      mode_strap_lo <= st[0];
   endtask

   // end of the reset pulse
   task automatic reset_off();
      rst_n <= 1'b1;
   endtask

   // straps move once the mode is latched, so a late sample shows up
   task automatic scramble();
      @(posedge clock);
      mode_select_pin <= ~mode_select_pin;
      mode_strap_hi <= ~mode_strap_hi;
      mode_strap_lo <= ~mode_strap_lo;
   endtask

   // falling request held one machine cycle, then released high
   task automatic irq_fall();
      @(posedge clock);
      irq_n <= 1'b0;
      repeat (MCYC_P) @(posedge clock);
      irq_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> dv/irc_top_tb.sv
// self-checking bench for the interrupt, reset and mode control block
`timescale 1ns/1ps
`default_nettype none
module irc_top_tb;
   // ****************************************
   // signals, model state and instances
   // ****************************************
   localparam int MC = 4; // clocks per machine cycle, shortened
   localparam int PU = 2; // settle delay in machine cycles, shortened
   logic clock = 1'b0;
   logic rst_n, irq_n, msel, s_hi, s_lo;
   logic [9:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'h1;
   logic instr_end = 1'b0;
   logic rti_final = 1'b0;
   logic timer_underflow = 1'b0;
   logic crc_bit_valid = 1'b0;
   logic crc_bit = 1'b0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, mcyc_en, core_run, int_entry, push_pc, reset_cycle;
   logic int_flags_sel, int_mask, ext_fetch;
   logic [11:0] vector;
   logic [1:0] op_mode;
   int n_fail = 0;
   int tests_run = 0;
   int e_mask, e_sel, e_pend, e_zf, e_tie, e_mode, e_crc, e_lock;

   // free-running clock
   always #50 clock = ~clock;

   irc_top #(.MCYC_DIV_P(MC), .POWERUP_MCYC_P(PU), .EDGE_SENSE(1'b1), .LOW_POWER(1'b1)) i_dut (
      .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_n(irq_n),
      .mode_select_pin(msel), .mode_strap_hi(s_hi), .mode_strap_lo(s_lo),
      .instr_end(instr_end), .rti_final(rti_final), .timer_underflow(timer_underflow),
      .crc_bit_valid(crc_bit_valid), .crc_bit(crc_bit), .mcyc_en(mcyc_en),
      .core_run(core_run), .int_entry(int_entry), .push_pc(push_pc),
      .reset_cycle(reset_cycle), .vector(vector), .int_flags_sel(int_flags_sel),
      .int_mask(int_mask), .op_mode(op_mode), .ext_fetch(ext_fetch));

   irc_partner #(.MCYC_P(MC)) i_partner (
      .clock(clock), .rst_n(rst_n), .irq_n(irq_n), .mode_select_pin(msel),
      .mode_strap_hi(s_hi), .mode_strap_lo(s_lo));

   // ****************************************
   // reporting and bus tasks
   // ****************************************
   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", n_fail, tests_run);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // negedges until a watched output is high, run ends on a hang
   task automatic wait_hi(input int k, output int n);
      n = 0;
      do begin
         @(negedge clock);
         n++;
         if (n > 5000) begin
            n_fail++;
            $display("wrong value at %0t: wait timed out", $time);
            stop_test();
         end
      end while ((k == 0 ? core_run : k == 1 ? reset_cycle : mcyc_en) !== 1'b1);
   endtask

   // one access held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd,
                      input logic [3:0] be, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= {24'h000000, wd};
      avs_byteenable <= be;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (avs_waitrequest !== 1'b0) begin
         chk(avs_waitrequest, 1'b0, "bus answer");
         stop_test();
      end
      // answer edge: take read data and release right here
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] idx);
      bus(1'b0, {idx, 2'b00}, 8'h00, 4'h1, rd);
   endtask

   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, {idx, 2'b00}, d, 4'h1, rd);
   endtask

   task automatic chk_status();
      rd_reg(irc_pkg::IDX_STATUS);
      chk(rd & 32'h77, 32'(e_lock * 64 + e_mode * 16 + e_pend * 4 + e_sel * 2 + e_mask),
          "status");
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   // reset pulse, settle delay, restart vector and mode latch
   task automatic do_reset(input logic sel, input logic [1:0] st);
      int n;
      i_partner.reset_on(sel, st);
      @(negedge clock);
      chk(int_mask, 1'b1, "mask in reset");
      chk(vector, irc_pkg::VEC_RST_NORMAL, "vector in reset");
      repeat (2 * MC) @(posedge clock);
      i_partner.reset_off();
      e_mode = sel ? 32'(st) : 0;
      e_mask = 1;
      e_sel = 0;
      e_pend = 0;
      e_zf = 0;
      e_tie = 0;
      e_lock = 0;
      wait_hi(1, n);
      chk(n >= (PU + 1) * MC - 1 && n <= (PU + 2) * MC + 1, 1, "settle delay");
      wait_hi(0, n);
      chk(n, MC, "reset cycle length");
      chk(vector, e_mode == 1 ? irc_pkg::VEC_RST_SELF : irc_pkg::VEC_RST_NORMAL, "restart");
      i_partner.scramble();
      @(negedge clock);
      chk(op_mode, e_mode, "mode");
      chk(ext_fetch, e_mode == 2, "external fetch");
   endtask

   // one instruction end on a machine-cycle boundary, maybe a return
   task automatic step(input logic return_from_int_instr);
      int n;
      int ent;
      int pushes;
      @(posedge clock);
      instr_end <= 1'b1;
      rti_final <= return_from_int_instr;
      wait_hi(2, n);
      @(posedge clock);
      instr_end <= 1'b0;
      rti_final <= 1'b0;
      if (return_from_int_instr) begin
         e_mask = 0;
         e_sel = 0;
      end
      ent = (e_pend || (e_zf && e_tie)) && !e_mask;
      @(negedge clock);
      chk(int_entry, ent, "entry start");
      if (ent != 0) begin
         e_mask = 1;
         e_sel = 1;
         e_pend = 0;
         chk(vector, e_mode == 1 ? irc_pkg::VEC_INT_SELF : irc_pkg::VEC_INT_NORMAL, "vec");
         n = 0;
         pushes = 0;
         while (int_entry === 1'b1 && n < 100) begin
            pushes += (push_pc === 1'b1);
            n++;
            @(negedge clock);
         end
         chk(n, MC, "entry length");
         chk(pushes, 1, "single push");
         chk(core_run, 1'b1, "back to run");
      end
      chk(int_mask, e_mask, "mask");
      chk(int_flags_sel, e_sel, "flag set");
   endtask

   // masked request, release by return, request during service
   task automatic int_flow();
      i_partner.irq_fall();
      e_pend = 1;
      step(1'b0);
      chk_status();
      step(1'b1);
      i_partner.irq_fall();
      e_pend = 1;
      step(1'b0);
      step(1'b1);
      step(1'b1);
   endtask

   // load both halves, shift random bits, read back; some modes freeze
   task automatic crc_flow();
      logic [7:0] a;
      logic [7:0] b;
      logic bt;
      rd_reg(irc_pkg::IDX_CRC_FIRST);
      chk(rd, 0, "crc reset");
      a = 8'($urandom);
      b = 8'($urandom);
      wr_reg(irc_pkg::IDX_CRC_FIRST, a);
      wr_reg(irc_pkg::IDX_CRC_SECOND, b);
      e_crc = {16'h0000, a, b};
      e_lock = (e_mode == 0 || e_mode == 2);
      @(posedge clock);
      repeat (20) begin
         bt = 1'($urandom);
         crc_bit_valid <= 1'b1;
         crc_bit <= bt;
         if (e_lock == 0) begin
            e_crc = ((e_crc << 1) & 32'hffff) ^ ((e_crc[15] ^ bt) ? 32'h1021 : 32'h0);
         end
         @(posedge clock);
      end
      crc_bit_valid <= 1'b0;
      rd_reg(irc_pkg::IDX_CRC_FIRST);
      chk(rd, e_crc >> 8, "crc high");
      rd_reg(irc_pkg::IDX_CRC_SECOND);
      chk(rd, e_crc & 32'hff, "crc low");
      chk_status();
   endtask

   // main sequence: every strap case, then timer request and odd accesses
   initial begin
      void'($urandom(18));
      for (int k = 0; k < 5; k++) begin
         do_reset(k < 4, k < 4 ? 2'(k) : 2'b11); // grounded select ignores straps 11
         int_flow();
         crc_flow();
      end
      wr_reg(irc_pkg::IDX_TIMER_STATUS, 8'h40);
      e_tie = 1;
      @(posedge clock);
      timer_underflow <= 1'b1;
      @(posedge clock);
      timer_underflow <= 1'b0;
      e_zf = 1;
      step(1'b0);
      rd_reg(irc_pkg::IDX_TIMER_STATUS);
      chk(rd & 32'hc0, 32'hc0, "zero flag set");
      e_zf = 0;
      rd_reg(irc_pkg::IDX_TIMER_STATUS);
      chk(rd & 32'hc0, 32'h40, "zero flag cleared");
      step(1'b1);
      bus(1'b1, 10'h028, 8'h5a, 4'h0, rd);
      rd_reg(irc_pkg::IDX_CRC_FIRST);
      chk(rd, e_crc >> 8, "disabled write");
      bus(1'b0, 10'h03c, 8'h00, 4'h1, rd);
      chk(rd, 0, "unmapped read");
      bus(1'b0, 10'h029, 8'h00, 4'h1, rd);
      chk(rd, 0, "misaligned read");
      stop_test();
   end

   // hang guard
   initial begin
      #(100 * 60000);
      n_fail++;
      $display("wrong value at %0t: run too long", $time);
      stop_test();
   end
endmodule
`default_nettype wire
